// *** src/rcwt_consts.svh ***
// register offsets, reset values, field positions and timing counts of the radio/wake register group
`ifndef RCWT_CONSTS_SVH
`define RCWT_CONSTS_SVH

`define RCWT_ADDR_W 10
// printed register offsets (byte addresses of the control port)
`define RCWT_OFF_PKT_FMT 10'h13e
`define RCWT_OFF_CH_LOW 10'h300
`define RCWT_OFF_CH_MID 10'h301
`define RCWT_OFF_CH_HIGH 10'h302
`define RCWT_OFF_TX_MOD 10'h306
`define RCWT_OFF_RX_POWER 10'h30c
`define RCWT_OFF_QUALITY 10'h30d
`define RCWT_OFF_PRAM_PAGE 10'h313
`define RCWT_OFF_TX_BASE 10'h314
`define RCWT_OFF_RX_BASE 10'h315
`define RCWT_OFF_PRESCALE 10'h316
`define RCWT_OFF_SLEEP 10'h317
`define RCWT_OFF_RELOAD_HI 10'h318
`define RCWT_OFF_RELOAD_LO 10'h319
`define RCWT_OFF_TMR_CTRL 10'h31a
`define RCWT_OFF_WAKE_STATUS 10'h31b
// own additions: interrupt status and mask
`define RCWT_OFF_IRQ_STATUS 10'h3f0
`define RCWT_OFF_IRQ_MASK 10'h3f1

// reset values
`define RCWT_RST_PKT_FMT 8'h00
`define RCWT_RST_CH_LOW 8'h80
`define RCWT_RST_CH_MID 8'ha9
`define RCWT_RST_CH_HIGH 8'h03
`define RCWT_RST_TX_MOD 8'h01
`define RCWT_RST_ZERO 8'h00
`define RCWT_RST_TX_BASE 8'h80
`define RCWT_RST_RELOAD 16'h0000

// field positions
`define RCWT_PRESCALE_MSB 2
`define RCWT_PRAM_PAGE_MSB 3
`define RCWT_SLEEP_MSB 6
`define RCWT_SLEEP_LSB 3
`define RCWT_WAKE_ON_TO_BIT 0
`define RCWT_CAL_EN_BIT 1
`define RCWT_FLAG_RST_BIT 0
`define RCWT_PREEMP_BIT 0
`define RCWT_ST_CAL_DONE_BIT 5
`define RCWT_ST_COLD_BIT 2
`define RCWT_ST_TIMEOUT_BIT 1
// interrupt bits: 0 timeout, 1 calibration done
`define RCWT_IRQ_TIMEOUT_BIT 0
`define RCWT_IRQ_CAL_BIT 1

// prescaler divide factors for codes 0..7
`define RCWT_DIV0 17'h0_0001
`define RCWT_DIV1 17'h0_0004
`define RCWT_DIV2 17'h0_0008
`define RCWT_DIV3 17'h0_0010
`define RCWT_DIV4 17'h0_0080
`define RCWT_DIV5 17'h0_0400
`define RCWT_DIV6 17'h0_2000
`define RCWT_DIV7 17'h1_0000

// timing
`define RCWT_CLK_HZ 25000000
`define RCWT_CAL_TIME_US 1000
`define RCWT_CAL_CYCLES ((`RCWT_CAL_TIME_US * (`RCWT_CLK_HZ / 1000)) / 1000)

`endif

// *** src/rcwt_pkg.sv ***
// types shared by the radio/wake register group
package rcwt_pkg;

	// packet format selector codes
	typedef enum logic [7:0] {
		RCWT_FMT_PACKET = 8'h00,
		RCWT_FMT_RX_STREAM = 8'h02,
		RCWT_FMT_TX_STREAM = 8'h03
	} rcwt_format_type;

	// sleep mode codes
	typedef enum logic [3:0] {
		RCWT_SLEEP_RETAIN_MEM = 4'h1,
		RCWT_SLEEP_RETAIN_XTAL = 4'h4,
		RCWT_SLEEP_RETAIN_BOTH = 4'h5,
		RCWT_SLEEP_RETAIN_MEM_RC = 4'hb
	} rcwt_sleep_type;

	// calibration sequencer states
	typedef enum logic [1:0] {
		RCWT_CAL_IDLE = 2'b00,
		RCWT_CAL_RUN = 2'b01,
		RCWT_CAL_DONE = 2'b10
	} rcwt_cal_state_type;

endpackage : rcwt_pkg

// *** src/rcwt_regs.sv ***
// register bank and wake-up timer of the low-power transceiver
//
// Operation
// - format select: 0 packet, 2/3 streaming
// - 24-bit channel word, three bytes, reset 0x03a980
// - tx bit0 pre-emphasis enable, resets on
// - read-only signed received power, reset zero
// - read-only signal quality readback, reset zero
// - transmit store base, resets to 128
// - receive store base, resets to 0
// - prescaler code divides slow clock 1..65536
// - prescaler takes effect on sleep-config write
// - 4-bit sleep mode select, four valid codes
// - wake on timeout only when enabled
// - 16-bit reload, high then low register
// - reload commits on low-byte write
// - control bit starts/disables RC calibration
// - flag-reset write clears timeout and cold-start
// - timeout flag latches until flag reset
// - calibration lasts 1 ms, then done
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "rcwt_consts.svh"

module rcwt_regs #(
	parameter int CAL_CYCLES = `RCWT_CAL_CYCLES
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// register port
	input wire logic [`RCWT_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	// radio readbacks and slow clock
	input wire logic [7:0] rx_power_in,
	input wire logic rx_power_valid,
	input wire logic [7:0] quality_in,
	input wire logic quality_valid,
	input wire logic slow_osc_tick,
	input wire logic cold_start_event,
	input wire logic in_sleep,
	// configuration outputs
	output logic [7:0] reg_rdata,
	output rcwt_pkg::rcwt_format_type packet_format_select,
	output logic [23:0] channel_frequency_word,
	output logic preemphasis_enable,
	output logic [6:0] controller_owned_bits,
	output logic [3:0] program_page,
	output logic [7:0] tx_store_base,
	output logic [7:0] rx_store_base,
	output logic [3:0] sleep_mode,
	output logic wake_request,
	output logic slow_osc_calibrate_enable,
	output logic slow_osc_calibration_done,
	output logic timeout_flag,
	output logic cold_start_flag,
	output logic irq
);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [7:0] fmt_reg;
	logic [23:0] chan_reg;
	logic [7:0] txmod_reg;
	logic [7:0] rxpow_reg;
	logic [7:0] qual_reg;
	logic [3:0] page_reg;
	logic [7:0] txbase_reg;
	logic [7:0] rxbase_reg;
	logic [2:0] presc_stage_reg;
	logic [2:0] presc_reg;
	logic [3:0] sleep_reg;
	logic wake_on_to_reg;
	logic [7:0] reload_hi_reg;
	logic [15:0] reload_reg;
	logic cal_en_reg;
	logic flag_rst_reg;
	logic to_flag_reg;
	logic cold_flag_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic [7:0] rdata_reg;
	logic [16:0] div_cnt_reg;
	logic [15:0] timer_reg;
	logic [31:0] cal_cnt_reg;
	rcwt_pkg::rcwt_cal_state_type cal_state_reg;
	rcwt_pkg::rcwt_cal_state_type cal_state_next;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	wire wr = reg_wr & clk_en;
	wire wr_fmt = wr && reg_addr == `RCWT_OFF_PKT_FMT;
	wire wr_ch0 = wr && reg_addr == `RCWT_OFF_CH_LOW;
	wire wr_ch1 = wr && reg_addr == `RCWT_OFF_CH_MID;
	wire wr_ch2 = wr && reg_addr == `RCWT_OFF_CH_HIGH;
	wire wr_txm = wr && reg_addr == `RCWT_OFF_TX_MOD;
	wire wr_page = wr && reg_addr == `RCWT_OFF_PRAM_PAGE;
	wire wr_txb = wr && reg_addr == `RCWT_OFF_TX_BASE;
	wire wr_rxb = wr && reg_addr == `RCWT_OFF_RX_BASE;
	wire wr_presc = wr && reg_addr == `RCWT_OFF_PRESCALE;
	wire wr_sleep = wr && reg_addr == `RCWT_OFF_SLEEP;
	wire wr_rld_hi = wr && reg_addr == `RCWT_OFF_RELOAD_HI;
	wire wr_rld_lo = wr && reg_addr == `RCWT_OFF_RELOAD_LO;
	wire wr_ctrl = wr && reg_addr == `RCWT_OFF_TMR_CTRL;
	wire wr_istat = wr && reg_addr == `RCWT_OFF_IRQ_STATUS;
	wire wr_imask = wr && reg_addr == `RCWT_OFF_IRQ_MASK;

	// flag reset acts on the write itself; the stored bit is only read back
	wire flag_clear = wr_ctrl & reg_wdata[`RCWT_FLAG_RST_BIT];

	// ---------------------------------------------------------------
	// prescaler and wake timer
	// ---------------------------------------------------------------
	logic [16:0] div_sel;
	// prescale code to divide factor
	always_comb begin
		case (presc_reg)
			3'd0: div_sel = `RCWT_DIV0;
			3'd1: div_sel = `RCWT_DIV1;
			3'd2: div_sel = `RCWT_DIV2;
			3'd3: div_sel = `RCWT_DIV3;
			3'd4: div_sel = `RCWT_DIV4;
			3'd5: div_sel = `RCWT_DIV5;
			3'd6: div_sel = `RCWT_DIV6;
			default: div_sel = `RCWT_DIV7;
		endcase
	end

	wire div_last = (div_cnt_reg + 17'h0_0001) >= div_sel;
	wire timer_tick = slow_osc_tick & div_last;
	wire timer_zero = timer_reg == 16'h0000;
	// gated so a frozen block neither wakes the device nor misses the flag it implies
	wire timeout_event = clk_en & timer_tick & timer_zero;

	// ---------------------------------------------------------------
	// calibration sequencer
	// ---------------------------------------------------------------
	wire cal_finished = cal_cnt_reg >= CAL_CYCLES - 1;
	// disabling calibration returns to idle from any state
	always_comb begin
		case (cal_state_reg)
			rcwt_pkg::RCWT_CAL_IDLE:
				cal_state_next = cal_en_reg ? rcwt_pkg::RCWT_CAL_RUN : rcwt_pkg::RCWT_CAL_IDLE;
			rcwt_pkg::RCWT_CAL_RUN:
				cal_state_next = !cal_en_reg ? rcwt_pkg::RCWT_CAL_IDLE :
					(cal_finished ? rcwt_pkg::RCWT_CAL_DONE : rcwt_pkg::RCWT_CAL_RUN);
			rcwt_pkg::RCWT_CAL_DONE:
				cal_state_next = cal_en_reg ? rcwt_pkg::RCWT_CAL_DONE : rcwt_pkg::RCWT_CAL_IDLE;
			default: cal_state_next = rcwt_pkg::RCWT_CAL_IDLE;
		endcase
	end
	wire cal_done_event = cal_state_reg == rcwt_pkg::RCWT_CAL_RUN &&
		cal_state_next == rcwt_pkg::RCWT_CAL_DONE;

	// ---------------------------------------------------------------
	// software-written registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fmt_reg <= `RCWT_RST_PKT_FMT;
			chan_reg <= {`RCWT_RST_CH_HIGH, `RCWT_RST_CH_MID, `RCWT_RST_CH_LOW};
			txmod_reg <= `RCWT_RST_TX_MOD;
			page_reg <= 4'h0;
			txbase_reg <= `RCWT_RST_TX_BASE;
			rxbase_reg <= `RCWT_RST_ZERO;
			presc_stage_reg <= 3'h0;
			presc_reg <= 3'h0;
			sleep_reg <= 4'h0;
			wake_on_to_reg <= 1'b0;
			reload_hi_reg <= `RCWT_RST_ZERO;
			reload_reg <= `RCWT_RST_RELOAD;
			cal_en_reg <= 1'b0;
			flag_rst_reg <= 1'b0;
			irq_mask_reg <= 2'b00;
		end else begin
			if (wr_fmt) fmt_reg <= reg_wdata;
			if (wr_ch0) chan_reg[7:0] <= reg_wdata;
			if (wr_ch1) chan_reg[15:8] <= reg_wdata;
			if (wr_ch2) chan_reg[23:16] <= reg_wdata;
			if (wr_txm) txmod_reg <= reg_wdata;
			if (wr_page) page_reg <= reg_wdata[`RCWT_PRAM_PAGE_MSB:0];
			if (wr_txb) txbase_reg <= reg_wdata;
			if (wr_rxb) rxbase_reg <= reg_wdata;
			if (wr_presc) presc_stage_reg <= reg_wdata[`RCWT_PRESCALE_MSB:0];
			if (wr_sleep) begin
				presc_reg <= presc_stage_reg;
				sleep_reg <= reg_wdata[`RCWT_SLEEP_MSB:`RCWT_SLEEP_LSB];
				wake_on_to_reg <= reg_wdata[`RCWT_WAKE_ON_TO_BIT];
			end
			if (wr_rld_hi) reload_hi_reg <= reg_wdata;
			if (wr_rld_lo) reload_reg <= {reload_hi_reg, reg_wdata};
			if (wr_ctrl) begin
				cal_en_reg <= reg_wdata[`RCWT_CAL_EN_BIT];
				flag_rst_reg <= reg_wdata[`RCWT_FLAG_RST_BIT];
			end
			if (wr_imask) irq_mask_reg <= reg_wdata[1:0];
		end
	end

	// ---------------------------------------------------------------
	// hardware state: readbacks, timer, flags, calibration
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rxpow_reg <= `RCWT_RST_ZERO;
			qual_reg <= `RCWT_RST_ZERO;
			div_cnt_reg <= 17'h0_0000;
			timer_reg <= `RCWT_RST_RELOAD;
			to_flag_reg <= 1'b0;
			cold_flag_reg <= 1'b0;
			cal_state_reg <= rcwt_pkg::RCWT_CAL_IDLE;
			cal_cnt_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (rx_power_valid) rxpow_reg <= rx_power_in;
			if (quality_valid) qual_reg <= quality_in;
			// a new reload restarts the count so the first period is exact
			if (wr_rld_lo) begin
				timer_reg <= {reload_hi_reg, reg_wdata};
				div_cnt_reg <= 17'h0_0000;
			end else if (slow_osc_tick) begin
				div_cnt_reg <= div_last ? 17'h0_0000 : div_cnt_reg + 17'h0_0001;
				if (timer_tick) timer_reg <= timer_zero ? reload_reg : timer_reg - 16'h0001;
			end
			// event wins over a clear in the same cycle
			if (timeout_event) to_flag_reg <= 1'b1;
			else if (flag_clear) to_flag_reg <= 1'b0;
			if (cold_start_event) cold_flag_reg <= 1'b1;
			else if (flag_clear) cold_flag_reg <= 1'b0;
			cal_state_reg <= cal_state_next;
			cal_cnt_reg <= cal_state_reg == rcwt_pkg::RCWT_CAL_RUN ?
				cal_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// interrupt status: sticky, write one to clear, set wins
	// ---------------------------------------------------------------
	wire [1:0] irq_set = {cal_done_event, timeout_event};
	wire [1:0] irq_clr = wr_istat ? reg_wdata[1:0] : 2'b00;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) irq_stat_reg <= 2'b00;
		else if (clk_en) irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ---------------------------------------------------------------
	// read path: data stand the cycle after the strobe
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	wire [7:0] status_word = {2'b00, cal_state_reg == rcwt_pkg::RCWT_CAL_DONE, 2'b00,
		cold_flag_reg, to_flag_reg, 1'b0};
	// write-only registers and unmapped addresses read as zero
	always_comb begin
		case (reg_addr)
			`RCWT_OFF_PKT_FMT: rd_mux = fmt_reg;
			`RCWT_OFF_CH_LOW: rd_mux = chan_reg[7:0];
			`RCWT_OFF_CH_MID: rd_mux = chan_reg[15:8];
			`RCWT_OFF_CH_HIGH: rd_mux = chan_reg[23:16];
			`RCWT_OFF_TX_MOD: rd_mux = txmod_reg;
			`RCWT_OFF_RX_POWER: rd_mux = rxpow_reg;
			`RCWT_OFF_QUALITY: rd_mux = qual_reg;
			`RCWT_OFF_PRAM_PAGE: rd_mux = {4'h0, page_reg};
			`RCWT_OFF_TX_BASE: rd_mux = txbase_reg;
			`RCWT_OFF_RX_BASE: rd_mux = rxbase_reg;
			`RCWT_OFF_SLEEP: rd_mux = {1'b0, sleep_reg, 2'b00, wake_on_to_reg};
			`RCWT_OFF_RELOAD_LO: rd_mux = reload_reg[7:0];
			`RCWT_OFF_TMR_CTRL: rd_mux = {6'h00, cal_en_reg, flag_rst_reg};
			`RCWT_OFF_WAKE_STATUS: rd_mux = status_word;
			`RCWT_OFF_IRQ_STATUS: rd_mux = {6'h00, irq_stat_reg};
			`RCWT_OFF_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) rdata_reg <= 8'h00;
		else if (clk_en) rdata_reg <= reg_rd ? rd_mux : 8'h00;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata = rdata_reg;
	assign packet_format_select = rcwt_pkg::rcwt_format_type'(fmt_reg);
	assign channel_frequency_word = chan_reg;
	assign preemphasis_enable = txmod_reg[`RCWT_PREEMP_BIT];
	assign controller_owned_bits = txmod_reg[7:1];
	assign program_page = page_reg;
	assign tx_store_base = txbase_reg;
	assign rx_store_base = rxbase_reg;
	assign sleep_mode = sleep_reg;
	assign wake_request = in_sleep & wake_on_to_reg & timeout_event;
	assign slow_osc_calibrate_enable = cal_en_reg;
	assign slow_osc_calibration_done = cal_state_reg == rcwt_pkg::RCWT_CAL_DONE;
	assign timeout_flag = to_flag_reg;
	assign cold_start_flag = cold_flag_reg;

endmodule : rcwt_regs

// *** tb/rcwt_regs_asserts.sv ***
// concurrent checks for the radio/wake register group
`timescale 1ns/1ns
`include "rcwt_consts.svh"
module rcwt_regs_asserts #(
	parameter int CAL_CYCLES = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port and events
	input wire logic clk_en,
	input wire logic [`RCWT_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic slow_osc_tick,
	input wire logic cold_start_event,
	input wire logic in_sleep,
	// observed outputs
	input wire logic [7:0] reg_rdata,
	input wire logic [23:0] channel_frequency_word,
	input wire logic preemphasis_enable,
	input wire logic [6:0] controller_owned_bits,
	input wire logic [7:0] tx_store_base,
	input wire logic wake_request,
	input wire logic slow_osc_calibrate_enable,
	input wire logic slow_osc_calibration_done,
	input wire logic timeout_flag,
	input wire logic cold_start_flag
);
	// ---------------------------------------------
	// helper decode and calibration age counter
	// ---------------------------------------------
	wire logic wr_ok;
	wire logic clr_hit;
	int cal_cnt_reg;
	assign wr_ok = clk_en && reg_wr;
	assign clr_hit = wr_ok && reg_addr == `RCWT_OFF_TMR_CTRL && reg_wdata[0];
	// saturates just past the late bound so a long enable cannot wrap it
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !slow_osc_calibrate_enable) cal_cnt_reg <= 0;
		else if (clk_en && cal_cnt_reg < CAL_CYCLES + 4) cal_cnt_reg <= cal_cnt_reg + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	a_chan_readback: assert property (clk_en && reg_rd && reg_addr == `RCWT_OFF_CH_LOW
		|=> reg_rdata == channel_frequency_word[7:0]) else $error("channel low readback wrong");
	a_chan_high_wr: assert property (wr_ok && reg_addr == `RCWT_OFF_CH_HIGH
		|=> channel_frequency_word[23:16] == $past(reg_wdata)) else $error("channel high not written");
	a_preemp_write: assert property (wr_ok && reg_addr == `RCWT_OFF_TX_MOD
		|=> {controller_owned_bits, preemphasis_enable} == $past(reg_wdata))
		else $error("modulation bits not written");
	a_tx_base_wr: assert property (wr_ok && reg_addr == `RCWT_OFF_TX_BASE
		|=> tx_store_base == $past(reg_wdata)) else $error("transmit base not written");
	a_flag_clear: assert property (clr_hit && !slow_osc_tick && !cold_start_event
		|=> !timeout_flag && !cold_start_flag) else $error("flags not cleared");
	a_flag_hold: assert property (timeout_flag && !clr_hit |=> timeout_flag)
		else $error("timeout flag dropped");
	a_cold_latch: assert property (cold_start_event && clk_en |=> cold_start_flag)
		else $error("cold start flag not set");
	a_wake_gate: assert property (wake_request |-> in_sleep ##1 timeout_flag)
		else $error("wake without sleep or timeout");
	a_cal_early: assert property (slow_osc_calibration_done |-> cal_cnt_reg >= CAL_CYCLES - 2)
		else $error("calibration done too soon");
	a_cal_bound: assert property (slow_osc_calibrate_enable && cal_cnt_reg >= CAL_CYCLES + 2
		|-> slow_osc_calibration_done) else $error("calibration done too late");
	a_cal_off: assert property ($fell(slow_osc_calibrate_enable)
		|-> ##[0:1] !slow_osc_calibration_done) else $error("done stays after disable");
	// main scenarios reached
	c_timeout: cover property ($rose(timeout_flag));
	c_wake: cover property (wake_request);
	c_cal_done: cover property ($rose(slow_osc_calibration_done));
endmodule : rcwt_regs_asserts

bind rcwt_regs rcwt_regs_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_rcwt_regs_asserts (
	.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .slow_osc_tick(slow_osc_tick),
	.cold_start_event(cold_start_event), .in_sleep(in_sleep), .reg_rdata(reg_rdata),
	.channel_frequency_word(channel_frequency_word), .preemphasis_enable(preemphasis_enable),
	.controller_owned_bits(controller_owned_bits), .tx_store_base(tx_store_base),
	.wake_request(wake_request), .slow_osc_calibrate_enable(slow_osc_calibrate_enable),
	.slow_osc_calibration_done(slow_osc_calibration_done), .timeout_flag(timeout_flag),
	.cold_start_flag(cold_start_flag));

// *** tb/rcwt_regs_test.sv ***
// self-checking bench for the radio/wake register group
`timescale 1ns/1ns
module rcwt_regs_test;
	typedef struct {logic [9:0] a; logic [7:0] d; bit w; logic [7:0] e;} rcwt_row_type;
	localparam int CAL = 20;
	logic ref_clk, reset_n, clk_en, reg_wr, reg_rd, rx_power_valid, quality_valid;
	logic slow_osc_tick, cold_start_event, in_sleep, preemphasis_enable, wake_request, irq;
	logic slow_osc_calibrate_enable, slow_osc_calibration_done, timeout_flag, cold_start_flag;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, rx_power_in, quality_in, reg_rdata, tx_store_base, rx_store_base;
	logic [23:0] channel_frequency_word;
	logic [6:0] controller_owned_bits;
	logic [3:0] program_page, sleep_mode;
	rcwt_pkg::rcwt_format_type packet_format_select;
	int error_cnt, comparisons, n0, nx, cnt;
	bit woke;
	logic irq_a;
	// reset reads, then write and read back; write-only, read-only and unmapped read zero
	rcwt_row_type rows[] = '{'{10'h13e,8'h00,0,8'h00}, '{10'h300,8'h00,0,8'h80},
		'{10'h301,8'h00,0,8'ha9}, '{10'h302,8'h00,0,8'h03}, '{10'h306,8'h00,0,8'h01},
		'{10'h30c,8'h00,0,8'h00}, '{10'h30d,8'h00,0,8'h00}, '{10'h313,8'h00,0,8'h00},
		'{10'h314,8'h00,0,8'h80}, '{10'h315,8'h00,0,8'h00}, '{10'h317,8'h00,0,8'h00},
		'{10'h319,8'h00,0,8'h00}, '{10'h31a,8'h00,0,8'h00}, '{10'h31b,8'h00,0,8'h00},
		'{10'h13e,8'h02,1,8'h02}, '{10'h13e,8'h03,1,8'h03}, '{10'h13e,8'h01,1,8'h01},
		'{10'h13e,8'h00,1,8'h00}, '{10'h300,8'h12,1,8'h12}, '{10'h301,8'h34,1,8'h34},
		'{10'h302,8'h56,1,8'h56}, '{10'h306,8'hfe,1,8'hfe}, '{10'h313,8'h0a,1,8'h0a},
		'{10'h314,8'h5a,1,8'h5a}, '{10'h315,8'ha5,1,8'ha5}, '{10'h317,8'h58,1,8'h58},
		'{10'h317,8'h20,1,8'h20}, '{10'h317,8'h08,1,8'h08}, '{10'h317,8'h28,1,8'h28},
		'{10'h316,8'h07,1,8'h00}, '{10'h318,8'hff,1,8'h00}, '{10'h30c,8'h55,1,8'h00},
		'{10'h3a0,8'h77,1,8'h00}};

	rcwt_regs #(.CAL_CYCLES(CAL)) u_rcwt_regs (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .rx_power_in(rx_power_in), .rx_power_valid(rx_power_valid),
		.quality_in(quality_in), .quality_valid(quality_valid), .slow_osc_tick(slow_osc_tick),
		.cold_start_event(cold_start_event), .in_sleep(in_sleep), .reg_rdata(reg_rdata),
		.packet_format_select(packet_format_select), .channel_frequency_word(channel_frequency_word),
		.preemphasis_enable(preemphasis_enable), .controller_owned_bits(controller_owned_bits),
		.program_page(program_page), .tx_store_base(tx_store_base), .rx_store_base(rx_store_base),
		.sleep_mode(sleep_mode), .wake_request(wake_request),
		.slow_osc_calibrate_enable(slow_osc_calibrate_enable),
		.slow_osc_calibration_done(slow_osc_calibration_done), .timeout_flag(timeout_flag),
		.cold_start_flag(cold_start_flag), .irq(irq));

	// -------------------------------
	// clock, tasks and watchdog
	// -------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// each strobe waits its own edge first, so back-to-back calls never clash
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("read data", {16'h0000, e}, {16'h0000, reg_rdata});
	endtask : rd
	// clears flags, restarts the timer and counts slow ticks up to the timeout
	task automatic measure(output int n, output bit w);
		wr(10'h31a, 8'h01);
		wr(10'h319, 8'h02);
		n = 0;
		w = 1'b0;
		while (n < 400 && timeout_flag !== 1'b1) begin
			@(posedge ref_clk);
			slow_osc_tick <= 1'b1;
			#1 w |= (wake_request === 1'b1);
			@(posedge ref_clk);
			slow_osc_tick <= 1'b0;
			n++;
			#1;
		end
	endtask : measure
	task automatic complete_run;
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		#(40 * 20000);
		error_cnt++;
		complete_run();
	end

	// -------------------------------
	// main sequence
	// -------------------------------
	initial begin
		{reset_n, reg_wr, reg_rd, rx_power_valid, quality_valid} = '0;
		{slow_osc_tick, cold_start_event, in_sleep, reg_addr, reg_wdata} = '0;
		{rx_power_in, quality_in} = 16'hf69c;
		clk_en = 1'b1;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk("channel word", 24'h56_3412, channel_frequency_word);
		chk("modulation", 24'h0000_fe, {controller_owned_bits, preemphasis_enable});
		chk("bases", 24'h005a_a5, {8'h00, tx_store_base, rx_store_base});
		chk("sleep mode", 24'h0000_05, {20'h0_0000, sleep_mode});
		chk("format page", 24'h00_000a, {12'h000, packet_format_select, program_page});
		// captured readbacks of the radio
		@(posedge ref_clk);
		{rx_power_valid, quality_valid} <= 2'b11;
		@(posedge ref_clk);
		{rx_power_valid, quality_valid} <= 2'b00;
		rd(10'h30c, 8'hf6);
		rd(10'h30d, 8'h9c);
		// timer periods scale with the divider, staged prescaler waits for sleep write
		in_sleep <= 1'b1;
		wr(10'h318, 8'h00);
		wr(10'h316, 8'h00);
		wr(10'h317, 8'h29);
		measure(n0, woke);
		chk("wake on", 24'h0000_01, {23'h00_0000, woke});
		wr(10'h316, 8'h01);
		measure(nx, woke);
		chk("staged period", 24'(n0), 24'(nx));
		wr(10'h317, 8'h29);
		measure(nx, woke);
		chk("div4 period", 24'(4 * n0), 24'(nx));
		wr(10'h316, 8'h02);
		wr(10'h317, 8'h28);
		measure(nx, woke);
		chk("div8 period", 24'(8 * n0), 24'(nx));
		chk("wake off", 24'h0000_00, {23'h00_0000, woke});
		// interrupt mask toggles the line, write one clears the status
		wr(10'h3f1, 8'h00);
		#1 irq_a = irq;
		wr(10'h3f1, 8'h03);
		#1 chk("irq mask", 24'h00_0001, {22'h00_0000, irq_a, irq});
		wr(10'h3f0, 8'h03);
		#1 chk("irq clear", 24'h0000_00, {23'h00_0000, irq});
		// flag latch survives, flag reset clears both flags
		@(posedge ref_clk);
		cold_start_event <= 1'b1;
		@(posedge ref_clk);
		cold_start_event <= 1'b0;
		rd(10'h31b, 8'h06);
		wr(10'h31a, 8'h01);
		rd(10'h31b, 8'h00);
		// calibration time
		wr(10'h31a, 8'h02);
		// look just after each edge so the flop has settled
		for (cnt = 0; cnt < 200 && slow_osc_calibration_done !== 1'b1; cnt++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("cal time", 24'h0000_01, {23'h00_0000, cnt >= CAL - 2 && cnt <= CAL + 2});
		rd(10'h31b, 8'h20);
		wr(10'h31a, 8'h00);
		rd(10'h31b, 8'h00);
		// frozen clock enable ignores writes
		clk_en <= 1'b0;
		wr(10'h314, 8'h11);
		clk_en <= 1'b1;
		rd(10'h314, 8'h5a);
		// mid-run reset brings back the documented reset values
		@(posedge ref_clk);
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		rd(10'h300, 8'h80);
		rd(10'h314, 8'h80);
		rd(10'h306, 8'h01);
		complete_run();
	end
endmodule : rcwt_regs_test
